// *** das_pkg.sv ***
// constants, op codes and modes of the dma address slice
// assumes one clock; users reference everything as das_pkg::name
package das_pkg;
    localparam int SLICE_W = 8;
    localparam int OP_W = 3;
    localparam int MODE_W = 3;
    localparam int MODE_SEL_W = 2;
    localparam int DIR_BIT = 2;
    localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
    localparam logic [SLICE_W-1:0] CNT_RST = 8'h00;

    typedef enum logic [OP_W-1:0] {
        OP_WRITE_MODE = 3'h0,
        OP_READ_MODE = 3'h1,
        OP_READ_COUNT = 3'h2,
        OP_READ_ADDRESS = 3'h3,
        OP_RESTORE = 3'h4,
        OP_LOAD_START = 3'h5,
        OP_LOAD_COUNT = 3'h6,
        OP_RUN = 3'h7
    } das_op_t;

    typedef enum logic [MODE_SEL_W-1:0] {
        MODE_COUNT_ZERO = 2'h0,
        MODE_COUNT_CMP = 2'h1,
        MODE_ADDR_CMP = 2'h2,
        MODE_CARRY_OUT = 2'h3
    } das_mode_t;
endpackage

// *** das_slice.sv ***
// one cascadable dma address slice: counters, saved registers, done logic
// assumes controller and memory run on mclk, so pins need no synchroniser;
// the testbench resolves three-state and open-collector wires from the enables
`timescale 1ns/1ps
module das_slice #(
    parameter int SLICE_W = das_pkg::SLICE_W
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [das_pkg::OP_W-1:0] op_code_in,
    input wire logic [SLICE_W-1:0] bidir_data_lines_in,
    output logic [SLICE_W-1:0] bidir_data_lines_out,
    output logic bidir_data_lines_oe,
    input wire logic address_output_enable_n,
    output logic [SLICE_W-1:0] memory_address_out,
    output logic memory_address_oe,
    input wire logic address_carry_in_n,
    output logic address_carry_out_n,
    input wire logic count_carry_in_n,
    output logic count_carry_out_n,
    output logic transfer_done_out,
    output logic transfer_done_oe
);

    if (SLICE_W < das_pkg::MODE_W) begin : g_width_check
        $error("slice width too small for mode readback");
    end

    localparam logic [SLICE_W-1:0] ALL_ONES = {SLICE_W{1'b1}};
    localparam logic [SLICE_W-1:0] ALL_ZERO = {SLICE_W{1'b0}};
    localparam logic [SLICE_W-1:0] ONE = {{(SLICE_W-1){1'b0}}, 1'b1};

    logic [das_pkg::MODE_W-1:0] mode_direction_reg_r;
    logic [SLICE_W-1:0] address_counter_r;
    logic [SLICE_W-1:0] start_address_reg_r;
    logic [SLICE_W-1:0] word_counter_r;
    logic [SLICE_W-1:0] saved_count_reg_r;
    logic [SLICE_W-1:0] address_counter_nxt;
    logic [SLICE_W-1:0] word_counter_nxt;
    das_pkg::das_op_t op;
    das_pkg::das_mode_t mode;
    logic count_down;
    logic word_up;
    logic word_down;
    logic done_high;

    // step one slice value up or down, wrapping
    function automatic logic [SLICE_W-1:0] step_val(
        input logic [SLICE_W-1:0] v,
        input logic down
    );
        step_val = down ? v - ONE : v + ONE;
    endfunction

    // terminal value where a slice passes its carry on
    function automatic logic at_terminal(
        input logic [SLICE_W-1:0] v,
        input logic down
    );
        at_terminal = down ? (v == ALL_ZERO) : (v == ALL_ONES);
    endfunction

    // instruction decode, combined with the mode bits
    assign op = das_pkg::das_op_t'(op_code_in);
    assign mode = das_pkg::das_mode_t'(mode_direction_reg_r[das_pkg::MODE_SEL_W-1:0]);
    assign count_down = mode_direction_reg_r[das_pkg::DIR_BIT];
    assign word_up = (mode == das_pkg::MODE_COUNT_CMP) || (mode == das_pkg::MODE_CARRY_OUT);
    assign word_down = (mode == das_pkg::MODE_COUNT_ZERO);

    // mode register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mode_direction_reg_r <= das_pkg::MODE_RST;
        end else if (op == das_pkg::OP_WRITE_MODE) begin
            mode_direction_reg_r <= bidir_data_lines_in[das_pkg::MODE_W-1:0];
        end
    end

    // address counter and its saved start
    always_comb begin
        case (op)
            das_pkg::OP_LOAD_START: address_counter_nxt = bidir_data_lines_in;
            das_pkg::OP_RESTORE: address_counter_nxt = start_address_reg_r;
            das_pkg::OP_RUN: begin
                if (!address_carry_in_n) begin
                    address_counter_nxt = step_val(address_counter_r, count_down);
                end else begin
                    address_counter_nxt = address_counter_r;
                end
            end
            default: address_counter_nxt = address_counter_r;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            address_counter_r <= das_pkg::CNT_RST;
        end else begin
            address_counter_r <= address_counter_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            start_address_reg_r <= das_pkg::CNT_RST;
        end else if (op == das_pkg::OP_LOAD_START) begin
            start_address_reg_r <= bidir_data_lines_in;
        end
    end

    // word counter and its saved count
    always_comb begin
        case (op)
            das_pkg::OP_LOAD_COUNT: begin
                if (mode == das_pkg::MODE_COUNT_CMP) begin
                    word_counter_nxt = ALL_ZERO;
                end else begin
                    word_counter_nxt = bidir_data_lines_in;
                end
            end
            das_pkg::OP_RESTORE: begin
                if (mode == das_pkg::MODE_COUNT_CMP) begin
                    word_counter_nxt = ALL_ZERO;
                end else begin
                    word_counter_nxt = saved_count_reg_r;
                end
            end
            das_pkg::OP_RUN: begin
                if (!count_carry_in_n && (word_up || word_down)) begin
                    word_counter_nxt = step_val(word_counter_r, word_down);
                end else begin
                    word_counter_nxt = word_counter_r;
                end
            end
            default: word_counter_nxt = word_counter_r;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            word_counter_r <= das_pkg::CNT_RST;
        end else begin
            word_counter_r <= word_counter_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            saved_count_reg_r <= das_pkg::CNT_RST;
        end else if (op == das_pkg::OP_LOAD_COUNT) begin
            saved_count_reg_r <= bidir_data_lines_in;
        end
    end

    // cascade carries, combinational from carry-in and state
    assign address_carry_out_n = !(!address_carry_in_n
        && at_terminal(address_counter_r, count_down));
    assign count_carry_out_n = !(!count_carry_in_n && (word_up || word_down)
        && at_terminal(word_counter_r, word_down));

    // transfer complete; released high means this slice agrees on done
    always_comb begin
        case (mode)
            das_pkg::MODE_COUNT_ZERO: begin
                if (!count_carry_in_n) begin
                    done_high = (word_counter_r == ONE);
                end else begin
                    done_high = (word_counter_r == ALL_ZERO);
                end
            end
            das_pkg::MODE_COUNT_CMP: begin
                if (!count_carry_in_n) begin
                    done_high = (step_val(word_counter_r, 1'b0) == saved_count_reg_r);
                end else begin
                    done_high = (word_counter_r == saved_count_reg_r);
                end
            end
            das_pkg::MODE_ADDR_CMP: done_high = (word_counter_r == address_counter_r);
            das_pkg::MODE_CARRY_OUT: done_high = 1'b0;
            default: done_high = 1'b0;
        endcase
    end

    assign transfer_done_out = 1'b0;
    assign transfer_done_oe = !done_high;

    // address pins
    assign memory_address_out = address_counter_r;
    assign memory_address_oe = !address_output_enable_n;

    // data read multiplexer
    always_comb begin
        case (op)
            das_pkg::OP_READ_MODE: begin
                bidir_data_lines_out = {{(SLICE_W-das_pkg::MODE_W){1'b1}},
                    mode_direction_reg_r};
                bidir_data_lines_oe = 1'b1;
            end
            das_pkg::OP_READ_COUNT: begin
                bidir_data_lines_out = word_counter_r;
                bidir_data_lines_oe = 1'b1;
            end
            das_pkg::OP_READ_ADDRESS: begin
                bidir_data_lines_out = address_counter_r;
                bidir_data_lines_oe = 1'b1;
            end
            default: begin
                bidir_data_lines_out = ALL_ZERO;
                bidir_data_lines_oe = 1'b0;
            end
        endcase
    end

    // checks

    sequence load_start_s;
        op_code_in == das_pkg::OP_LOAD_START;
    endsequence

    sequence idle_gap_s;
        (op_code_in != das_pkg::OP_LOAD_START) [*1] ##1
            (op_code_in == das_pkg::OP_RESTORE);
    endsequence

    sequence run_up_s;
        (op_code_in == das_pkg::OP_RUN) && !address_carry_in_n
            && !mode_direction_reg_r[das_pkg::DIR_BIT];
    endsequence

    sequence run_down_s;
        (op_code_in == das_pkg::OP_RUN) && !address_carry_in_n
            && mode_direction_reg_r[das_pkg::DIR_BIT];
    endsequence

    load_address_a: assert property (@(posedge mclk) disable iff (sys_rst)
        load_start_s |=> (address_counter_r == $past(bidir_data_lines_in))
            && (start_address_reg_r == $past(bidir_data_lines_in)))
        else $error("load address did not fill counter and start register");

    repeat_transfer_a: assert property (@(posedge mclk) disable iff (sys_rst)
        load_start_s ##1 idle_gap_s |=> (address_counter_r == $past(start_address_reg_r)))
        else $error("restore did not return address counter to start");

    address_up_a: assert property (@(posedge mclk) disable iff (sys_rst)
        run_up_s |=> (address_counter_r == step_val($past(address_counter_r), 1'b0)))
        else $error("address counter did not increment");

    address_down_a: assert property (@(posedge mclk) disable iff (sys_rst)
        run_down_s |=> (address_counter_r == step_val($past(address_counter_r), 1'b1)))
        else $error("address counter did not decrement");

    address_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ((op_code_in == das_pkg::OP_RUN) && address_carry_in_n)
            || (op_code_in inside {das_pkg::OP_WRITE_MODE, das_pkg::OP_READ_MODE,
                das_pkg::OP_READ_COUNT, das_pkg::OP_READ_ADDRESS})
            |=> $stable(address_counter_r))
        else $error("address counter moved while disabled");

    word_mode0_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (op_code_in == das_pkg::OP_RUN) && !count_carry_in_n
            && (mode_direction_reg_r[1:0] == 2'h0)
            |=> (word_counter_r == step_val($past(word_counter_r), 1'b1)))
        else $error("word counter did not decrement in mode 0");

    word_mode2_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (op_code_in == das_pkg::OP_RUN) && (mode_direction_reg_r[1:0] == 2'h2)
            |=> $stable(word_counter_r))
        else $error("word counter moved in mode 2");

    count_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (op_code_in == das_pkg::OP_LOAD_COUNT) && (mode_direction_reg_r[1:0] == 2'h1)
            |=> (word_counter_r == ALL_ZERO)
            && (saved_count_reg_r == $past(bidir_data_lines_in)))
        else $error("mode 1 load count did not clear word counter");

    load_count_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (op_code_in == das_pkg::OP_LOAD_COUNT) && (mode_direction_reg_r[1:0] != 2'h1)
            |=> (word_counter_r == $past(bidir_data_lines_in))
            && (saved_count_reg_r == $past(bidir_data_lines_in)))
        else $error("load count did not fill both word registers");

    done_mode3_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (mode_direction_reg_r[1:0] == 2'h3) |-> transfer_done_oe)
        else $error("done released in mode 3");

    done_mode0_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (mode_direction_reg_r[1:0] == 2'h0) && !count_carry_in_n
            |-> (transfer_done_oe == (word_counter_r != ONE)))
        else $error("mode 0 done wrong at count one");

    done_mode2_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (mode_direction_reg_r[1:0] == 2'h2)
            |-> (transfer_done_oe == (word_counter_r != address_counter_r)))
        else $error("mode 2 done does not follow address compare");

    read_mux_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (op_code_in == das_pkg::OP_READ_COUNT)
            |-> bidir_data_lines_oe && (bidir_data_lines_out == word_counter_r))
        else $error("word counter not driven on read");

    data_float_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (op_code_in inside {das_pkg::OP_RESTORE, das_pkg::OP_RUN})
            |-> !bidir_data_lines_oe)
        else $error("data lines driven during restore or run");

    addr_pins_a: assert property (@(posedge mclk) disable iff (sys_rst)
        memory_address_oe == !address_output_enable_n)
        else $error("address output enable wrong");

    carry_out_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !address_carry_in_n && !mode_direction_reg_r[das_pkg::DIR_BIT]
            && (address_counter_r == ALL_ONES) |-> !address_carry_out_n)
        else $error("address carry out missing at wrap");

    done_zero_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (mode_direction_reg_r[1:0] == 2'h0) && count_carry_in_n
            |-> (transfer_done_oe == (word_counter_r != ALL_ZERO)))
        else $error("mode 0 done wrong at count zero");

    done_cmp_next_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (mode_direction_reg_r[1:0] == 2'h1) && !count_carry_in_n
            |-> (transfer_done_oe == (step_val(word_counter_r, 1'b0) != saved_count_reg_r)))
        else $error("mode 1 done wrong one before saved count");

    done_cmp_equal_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (mode_direction_reg_r[1:0] == 2'h1) && count_carry_in_n
            |-> (transfer_done_oe == (word_counter_r != saved_count_reg_r)))
        else $error("mode 1 done wrong at saved count");

    restore_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (op_code_in == das_pkg::OP_RESTORE) && (mode_direction_reg_r[1:0] == 2'h1)
            |=> (word_counter_r == ALL_ZERO))
        else $error("mode 1 restore did not clear word counter");

    restore_count_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (op_code_in == das_pkg::OP_RESTORE) && (mode_direction_reg_r[1:0] != 2'h1)
            |=> (word_counter_r == $past(saved_count_reg_r)))
        else $error("restore did not copy saved count");

    restore_address_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (op_code_in == das_pkg::OP_RESTORE)
            |=> (address_counter_r == $past(start_address_reg_r)))
        else $error("restore did not copy start address");

    mode_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (op_code_in == das_pkg::OP_WRITE_MODE)
            |=> (mode_direction_reg_r == $past(bidir_data_lines_in[das_pkg::MODE_W-1:0])))
        else $error("mode register not written");

    mode_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (op_code_in == das_pkg::OP_READ_MODE) |-> bidir_data_lines_oe
            && (bidir_data_lines_out[das_pkg::MODE_W-1:0] == mode_direction_reg_r)
            && (&bidir_data_lines_out[SLICE_W-1:das_pkg::MODE_W]))
        else $error("mode read not padded with ones");

    read_address_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (op_code_in == das_pkg::OP_READ_ADDRESS)
            |-> bidir_data_lines_oe && (bidir_data_lines_out == address_counter_r))
        else $error("address counter not driven on read");

    word_up_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (op_code_in == das_pkg::OP_RUN) && !count_carry_in_n
            && mode_direction_reg_r[0]
            |=> (word_counter_r == step_val($past(word_counter_r), 1'b0)))
        else $error("word counter did not increment in mode 1 or 3");

    word_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (op_code_in == das_pkg::OP_RUN) && count_carry_in_n |=> $stable(word_counter_r))
        else $error("word counter moved without carry in");

    count_carry_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (mode_direction_reg_r[1:0] == 2'h3) && !count_carry_in_n
            && (word_counter_r == ALL_ONES) |-> !count_carry_out_n)
        else $error("word carry out missing at wrap");

    count_carry_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (mode_direction_reg_r[1:0] == 2'h2) |-> count_carry_out_n)
        else $error("word carry out active in mode 2");

endmodule

// *** das_bus_model.sv ***
// controller and memory side of the slice: resolves data, address and done wires
// assumes the bench supplies controller drive; released data and address lines show inverted last value, released done is pulled high
`timescale 1ns/1ps
module das_bus_model (
    input wire logic mclk,
    input wire logic [7:0] dev_data,
    input wire logic dev_data_oe,
    input wire logic [7:0] ctl_data,
    input wire logic ctl_data_oe,
    input wire logic [7:0] dev_addr,
    input wire logic dev_addr_oe,
    input wire logic done_pull,
    output logic [7:0] data_wire,
    output logic [7:0] addr_wire,
    output logic done_wire
);
    logic [7:0] data_last_r;
    logic [7:0] addr_last_r;
    // floating bus must not look like a held value
    always_comb begin
        if (dev_data_oe) begin
            data_wire = dev_data;
        end else if (ctl_data_oe) begin
            data_wire = ctl_data;
        end else begin
            data_wire = ~data_last_r;
        end
        addr_wire = dev_addr_oe ? dev_addr : ~addr_last_r;
        done_wire = done_pull ? 1'b0 : 1'b1; // pull-up
    end
    always_ff @(posedge mclk) begin
        data_last_r <= data_wire;
        addr_last_r <= addr_wire;
    end
endmodule

// *** test_dma_address_slice.sv ***
// self-checking bench for the dma address slice
// assumes the slice and bus model; all stimulus on rising mclk edges
`timescale 1ns/1ps
module test_dma_address_slice;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] op = 3'h1;
    logic [7:0] din = 8'h00;
    logic ctl_oe = 1'b0;
    logic oe_n = 1'b0;
    logic addr_cin_n = 1'b1;
    logic cnt_cin_n = 1'b1;
    logic [7:0] d_out, data_wire, addr, addr_wire;
    logic d_oe, a_oe, addr_cout_n, cnt_cout_n, done_val, done_oe, done_wire;
    int err_total = 0;
    int comparisons = 0;

    always #2.5 mclk = ~mclk;

    das_slice DUT (.mclk(mclk), .sys_rst(sys_rst), .op_code_in(op),
        .bidir_data_lines_in(data_wire), .bidir_data_lines_out(d_out),
        .bidir_data_lines_oe(d_oe), .address_output_enable_n(oe_n),
        .memory_address_out(addr), .memory_address_oe(a_oe),
        .address_carry_in_n(addr_cin_n), .address_carry_out_n(addr_cout_n),
        .count_carry_in_n(cnt_cin_n), .count_carry_out_n(cnt_cout_n),
        .transfer_done_out(done_val), .transfer_done_oe(done_oe));
    das_bus_model bus (.mclk(mclk), .dev_data(d_out), .dev_data_oe(d_oe),
        .ctl_data(din), .ctl_data_oe(ctl_oe), .dev_addr(addr), .dev_addr_oe(a_oe),
        .done_pull(done_oe), .data_wire(data_wire), .addr_wire(addr_wire),
        .done_wire(done_wire));

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic step(input logic [2:0] o, input logic [7:0] d, input int a_cin,
        input int w_cin);
        @(posedge mclk);
        op <= o;
        din <= d;
        addr_cin_n <= 1'(a_cin);
        cnt_cin_n <= 1'(w_cin);
        ctl_oe <= (o == 3'h0 || o == 3'h5 || o == 3'h6);
        #1;
    endtask

    task automatic down_wrap_test();
        step(3'h0, 8'hfc, 1, 1);
        step(3'h5, 8'h01, 1, 1);
        step(3'h7, 8'h00, 0, 1);
        chk("data float", 8'h00, {7'h0, d_oe});
        step(3'h7, 8'h00, 0, 1);
        chk("addr down", 8'h00, addr_wire);
        chk("carry at zero", 8'h00, {7'h0, addr_cout_n});
        step(3'h7, 8'h00, 1, 1);
        chk("addr wrap", 8'hff, addr_wire);
        chk("carry idle", 8'h01, {7'h0, addr_cout_n});
        step(3'h4, 8'h00, 1, 1);
        chk("addr held", 8'hff, addr_wire);
        step(3'h1, 8'h00, 1, 1);
        chk("restore", 8'h01, addr_wire);
        chk("mode read", 8'hfc, data_wire);
        @(posedge mclk);
        oe_n <= 1'b1;
        #1;
        chk("addr oe off", 8'h00, {7'h0, a_oe});
        @(posedge mclk);
        oe_n <= 1'b0;
    endtask

    task automatic mode0_test();
        step(3'h0, 8'h00, 1, 1);
        step(3'h6, 8'h03, 1, 1);
        step(3'h7, 8'h00, 1, 0);
        chk("m0 done 3", 8'h00, {7'h0, done_wire});
        step(3'h7, 8'h00, 1, 0);
        step(3'h7, 8'h00, 1, 1);
        chk("m0 no borrow", 8'h00, {7'h0, done_wire});
        step(3'h7, 8'h00, 1, 0);
        chk("m0 done 1", 8'h01, {7'h0, done_wire});
        step(3'h2, 8'h00, 1, 1);
        chk("m0 count", 8'h00, data_wire);
        chk("m0 done 0", 8'h01, {7'h0, done_wire});
    endtask

    task automatic mode1_test();
        step(3'h0, 8'h01, 1, 1);
        step(3'h6, 8'h02, 1, 1);
        step(3'h7, 8'h00, 1, 0);
        chk("m1 cleared", 8'h00, {7'h0, done_wire});
        step(3'h7, 8'h00, 1, 0);
        chk("m1 done lo", 8'h01, {7'h0, done_wire});
        step(3'h2, 8'h00, 1, 1);
        chk("m1 count", 8'h02, data_wire);
        chk("m1 done hi", 8'h01, {7'h0, done_wire});
        step(3'h4, 8'h00, 1, 1);
        step(3'h2, 8'h00, 1, 1);
        chk("m1 restore", 8'h00, data_wire);
    endtask

    task automatic mode2_test();
        step(3'h0, 8'h02, 1, 1);
        step(3'h5, 8'h10, 1, 1);
        step(3'h6, 8'h12, 1, 1);
        step(3'h7, 8'h00, 0, 0);
        chk("m2 not yet", 8'h00, {7'h0, done_wire});
        chk("m2 cnt carry", 8'h01, {7'h0, cnt_cout_n});
        step(3'h7, 8'h00, 0, 0);
        step(3'h3, 8'h00, 1, 1);
        chk("m2 addr up", 8'h12, data_wire);
        chk("m2 done", 8'h01, {7'h0, done_wire});
        step(3'h2, 8'h00, 1, 1);
        chk("m2 hold", 8'h12, data_wire);
        step(3'h5, 8'hff, 1, 1);
        step(3'h7, 8'h00, 0, 1);
        chk("up carry at ff", 8'h00, {7'h0, addr_cout_n});
        step(3'h4, 8'h00, 1, 1);
        chk("addr up wrap", 8'h00, addr_wire);
        step(3'h3, 8'h00, 1, 1);
        chk("m2 repeat", 8'hff, data_wire);
    endtask

    task automatic mode3_test();
        step(3'h0, 8'h03, 1, 1);
        step(3'h6, 8'hfe, 1, 1);
        step(3'h7, 8'h00, 1, 0);
        chk("m3 carry fe", 8'h01, {7'h0, cnt_cout_n});
        step(3'h7, 8'h00, 1, 0);
        chk("m3 carry ff", 8'h00, {7'h0, cnt_cout_n});
        chk("m3 done", 8'h00, {7'h0, done_wire});
        chk("done level", 8'h00, {7'h0, done_val});
        step(3'h4, 8'h00, 1, 1);
        step(3'h2, 8'h00, 1, 1);
        chk("m3 restore", 8'hfe, data_wire);
        step(3'h1, 8'h00, 1, 1);
        chk("m3 mode", 8'hfb, data_wire);
    endtask

    task automatic complete_run();
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        down_wrap_test();
        mode0_test();
        mode1_test();
        mode2_test();
        mode3_test();
        complete_run();
    end

    initial begin
        #10000;
        err_total++;
        complete_run();
    end
endmodule
